// >>> interrupt_source_vectoring.sv
`timescale 1ns/100ps
// Functional notes
// - instruction interrupts ignore enable and priority
// - undefined opcode vectors via fffdc
// - overflow trap only when overflow flag set
// - break via fffe4, ff marker relocates
// - traps 0-63, low 32 share peripheral vectors
// - traps 0-31 save, clear, restore stack select
// - traps 32-63 keep stack select unchanged
// - reset pin low gives reset vector ffffc
// - nmi pin falling edge vectors via ffff8
// - watchdog request vectors via ffff0
// - debug flag steps after each instruction
// - address match before instruction, via fffe8
// - no match unless first instruction byte
// - maskable means enable flag gates it
// - peripherals maskable, share trap 5-31 entries
// - separate peripheral request inputs accepted
// - any low key pin raises key request
// - edge pins raise on selected edges
// - fixed table fffdc to top, four bytes
// - accepted request fetches vector then branches
// - relocatable table base plus four times n
// - request bit set on request, cleared on accept
// - global enable reads zero after reset
module interrupt_source_vectoring
    import intvec_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic undefined_opcode_instr,
    input wire logic overflow_trap_instr,
    input wire logic overflow_flag,
    input wire logic break_instr,
    input wire logic trap_instr,
    input wire logic [5:0] trap_number,
    input wire logic instr_retired,
    input wire logic debug_flag,
    input wire logic instr_start,
    input wire logic [19:0] instr_addr,
    input wire logic addr_match_enable,
    input wire logic [19:0] addr_match_value,
    input wire logic watchdog_req,
    input wire logic debugger_break_int,
    input wire logic nmi_pin_n,
    input wire logic [KEY_PINS-1:0] key_input_pin_n,
    input wire logic ext_edge_int_a,
    input wire logic ext_edge_int_b,
    input wire logic ext_edge_int_c,
    input wire logic [1:0] ext_edge_sel_a,
    input wire logic [1:0] ext_edge_sel_b,
    input wire logic [1:0] ext_edge_sel_c,
    input wire logic [31:0] periph_req,
    input wire logic [31:0] req_clear,
    input wire logic int_enable_set,
    input wire logic int_enable_clear,
    input wire logic stack_select_wr,
    input wire logic stack_select_wdata,
    input wire logic int_return,
    input wire logic [19:0] vector_table_base,
    output logic vec_rd_req,
    output logic [19:0] vec_rd_addr,
    input wire logic vec_rd_ack,
    input wire logic [31:0] vec_rd_data,
    output logic branch_valid,
    output logic [19:0] branch_addr,
    output logic branch_fixed,
    output logic [5:0] branch_number,
    output logic int_enable,
    output logic stack_select,
    output logic [31:0] req_pending
);

    // ==========================================================
    // decode helpers
    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = i[4:0];
            end
        end
        return idx;
    endfunction : lowest_set
    function automatic logic [19:0] fixed_addr(input logic [4:0] sp);
        logic [19:0] a;
        case (sp)
            5'(SP_RESET): a = VEC_RESET;
            5'(SP_DBC): a = VEC_DBC;
            5'(SP_WDT): a = VEC_WDT;
            5'(SP_NMI): a = VEC_NMI;
            5'(SP_UND): a = VEC_UNDEF;
            5'(SP_OVF): a = VEC_OVF;
            5'(SP_BRK): a = VEC_BRK;
            5'(SP_AMATCH): a = VEC_AMATCH;
            5'(SP_STEP): a = VEC_STEP;
            default: a = VEC_RESET;
        endcase
        return a;
    endfunction : fixed_addr
    function automatic logic [19:0] reloc_addr(input logic [19:0] base, input logic [5:0] n);
        return base + {12'h000, n, 2'b00};
    endfunction : reloc_addr

    // ==========================================================
    // pin conditioning
    logic [2:0] ext_edge;
    logic [0:0] nmi_fall;
    logic [KEY_PINS-1:0] key_level;

    input_conditioner #(.WIDTH(3)) u_ext (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in({ext_edge_int_c, ext_edge_int_b, ext_edge_int_a}),
        .edge_sel({ext_edge_sel_c, ext_edge_sel_b, ext_edge_sel_a}),
        .level_q(),
        .edge_q(ext_edge)
    );
    input_conditioner #(.WIDTH(1)) u_nmi (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(nmi_pin_n),
        .edge_sel(EDGE_FALL),
        .level_q(),
        .edge_q(nmi_fall)
    );
    input_conditioner #(.WIDTH(KEY_PINS)) u_key (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(key_input_pin_n),
        .edge_sel('0),
        .level_q(key_level),
        .edge_q()
    );

    // ==========================================================
    // state
    typedef struct packed {
        fsm_state_t st;
        logic [SPEC_N-1:0] spec;
        logic [5:0] trap_num;
        logic [31:0] req;
        logic ie;
        logic usel;
        logic usel_saved;
        logic restore_armed;
        logic [4:0] cur_spec;
        logic cur_periph;
        logic cur_reloc;
        logic [5:0] cur_num;
        logic rd_req;
        logic [19:0] rd_addr;
        logic br_valid;
        logic [19:0] br_addr;
        logic br_fixed;
        logic [5:0] br_num;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [SPEC_N-1:0] spec_set;
    logic [31:0] req_set;
    logic [31:0] maskable_ready;
    logic amatch_hit;
    logic brk_marked;

    // the match is only compared when the core flags a first instruction byte
    assign amatch_hit = addr_match_enable & instr_start
        & (instr_addr == addr_match_value);
    assign brk_marked = (vec_rd_data[7:0] == BRK_RELOC_MARK);

    always_comb
    begin
        spec_set = '0;
        spec_set[SP_DBC] = debugger_break_int;
        spec_set[SP_WDT] = watchdog_req;
        spec_set[SP_NMI] = nmi_fall[0];
        spec_set[SP_UND] = undefined_opcode_instr;
        spec_set[SP_OVF] = overflow_trap_instr & overflow_flag;
        spec_set[SP_BRK] = break_instr;
        spec_set[SP_TRAP] = trap_instr;
        spec_set[SP_AMATCH] = amatch_hit;
        spec_set[SP_STEP] = instr_retired & debug_flag;
        req_set = periph_req & PERIPH_IN_MASK;
        req_set[KEY_VEC] = ~(&key_level);
        req_set[EXT_A_VEC] = ext_edge[0];
        req_set[EXT_B_VEC] = ext_edge[1];
        req_set[EXT_C_VEC] = ext_edge[2];
    end

    // the enable flag gates every peripheral source, never the specials
    assign maskable_ready = s_q.ie ? (s_q.req & MASKABLE_MASK) : 32'h0000_0000;

    always_comb
    begin
        s_d = s_q;
        s_d.br_valid = 1'b0;
        s_d.ie = int_enable_set | (s_q.ie & ~int_enable_clear); // set beats clear
        if (stack_select_wr)
        begin
            s_d.usel = stack_select_wdata;
        end
        // a single saved copy: nested shared traps restore only the innermost
        if (int_return && s_q.restore_armed)
        begin
            s_d.usel = s_q.usel_saved;
            s_d.restore_armed = 1'b0;
        end
        if (trap_instr)
        begin
            s_d.trap_num = trap_number;
        end
        s_d.req = s_q.req & ~req_clear;
        case (s_q.st)
            ST_IDLE:
            begin
                if (|s_q.spec)
                begin
                    s_d.cur_spec = lowest_set({22'h000000, s_q.spec});
                    s_d.cur_periph = 1'b0;
                    s_d.cur_reloc = (lowest_set({22'h000000, s_q.spec}) == 5'(SP_TRAP));
                    s_d.cur_num = s_q.trap_num;
                    s_d.rd_req = 1'b1;
                    s_d.rd_addr = (lowest_set({22'h000000, s_q.spec}) == 5'(SP_TRAP))
                        ? reloc_addr(vector_table_base, s_q.trap_num)
                        : fixed_addr(lowest_set({22'h000000, s_q.spec}));
                    s_d.st = ST_FETCH;
                end
                else if (|maskable_ready)
                begin
                    s_d.cur_spec = 5'h1f;
                    s_d.cur_periph = 1'b1;
                    s_d.cur_reloc = 1'b1;
                    s_d.cur_num = {1'b0, lowest_set(maskable_ready)};
                    s_d.rd_req = 1'b1;
                    s_d.rd_addr = reloc_addr(vector_table_base, {1'b0, lowest_set(maskable_ready)});
                    s_d.st = ST_FETCH;
                end
            end
            ST_FETCH, ST_RELOC:
            begin
                if (vec_rd_ack)
                begin
                    s_d.rd_req = 1'b0;
                    if (s_q.st == ST_FETCH && s_q.cur_spec == 5'(SP_BRK) && brk_marked)
                    begin
                        s_d.cur_reloc = 1'b1;
                        s_d.cur_num = TRAP_BRK_NUM;
                        s_d.rd_req = 1'b1;
                        s_d.rd_addr = reloc_addr(vector_table_base, TRAP_BRK_NUM);
                        s_d.st = ST_RELOC;
                    end
                    else
                    begin
                        s_d.br_valid = 1'b1;
                        s_d.br_addr = vec_rd_data[19:0];
                        s_d.br_fixed = ~s_q.cur_reloc;
                        s_d.br_num = s_q.cur_num;
                        if (s_q.cur_periph)
                        begin
                            s_d.req[s_q.cur_num[4:0]] = 1'b0;
                        end
                        else
                        begin
                            s_d.spec[s_q.cur_spec[3:0]] = 1'b0;
                        end
                        if (s_q.cur_reloc && s_q.cur_num <= TRAP_SHARED_LAST)
                        begin
                            s_d.usel_saved = s_d.usel;
                            s_d.usel = 1'b0;
                            s_d.restore_armed = 1'b1;
                        end
                        // numbers above the shared range leave the stack choice alone
                        s_d.st = ST_BRANCH;
                    end
                end
            end
            ST_BRANCH:
            begin
                s_d.st = ST_IDLE;
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase
        // new events win over the clear of the same cycle
        s_d.spec = s_d.spec | spec_set;
        s_d.req = s_d.req | req_set;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.spec[SP_RESET] <= 1'b1;
            s_q.ie <= IE_RST;
            s_q.usel <= USEL_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign vec_rd_req = s_q.rd_req;
    assign vec_rd_addr = s_q.rd_addr;
    assign branch_valid = s_q.br_valid;
    assign branch_addr = s_q.br_addr;
    assign branch_fixed = s_q.br_fixed;
    assign branch_number = s_q.br_num;
    assign int_enable = s_q.ie;
    assign stack_select = s_q.usel;
    assign req_pending = s_q.req;

    // ==========================================================
    // checks
    sequence s_fetch_ack;
        s_q.st == ST_FETCH && vec_rd_ack;
    endsequence

    sequence s_brk_marked;
        s_fetch_ack ##0 (s_q.cur_spec == 5'(SP_BRK) && brk_marked);
    endsequence

    a_reset_vector: assert property (@(posedge core_clk) disable iff (!reset_n)
        (vec_rd_req && s_q.cur_spec == 5'(SP_RESET)) |-> vec_rd_addr == VEC_RESET)
        else $error("reset vector address wrong");
    a_overflow_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        (overflow_trap_instr && !overflow_flag && !s_q.spec[SP_OVF]) |=> !s_q.spec[SP_OVF])
        else $error("overflow interrupt raised with flag clear");
    a_brk_relocate: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_brk_marked |=> (vec_rd_req && vec_rd_addr == $past(vector_table_base)
            && !branch_valid))
        else $error("break marker did not relocate");
    a_fetch_branch: assert property (@(posedge core_clk) disable iff (!reset_n)
        (s_fetch_ack ##0 !(s_q.cur_spec == 5'(SP_BRK) && brk_marked))
        |=> (branch_valid && branch_addr == $past(vec_rd_data[19:0])) ##1 !branch_valid)
        else $error("vector fetch did not branch");
    a_low_trap_isp: assert property (@(posedge core_clk) disable iff (!reset_n)
        (branch_valid && !branch_fixed && branch_number <= TRAP_SHARED_LAST)
        |-> !stack_select)
        else $error("shared trap kept stack select set");
    a_high_trap_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
        (branch_valid && !branch_fixed && branch_number > TRAP_SHARED_LAST
            && !$past(stack_select_wr) && !$past(int_return))
        |-> stack_select == $past(stack_select))
        else $error("high trap changed stack select");
    a_mask_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($rose(vec_rd_req) && s_q.cur_periph) |-> $past(int_enable))
        else $error("maskable request taken while disabled");
    a_req_cleared: assert property (@(posedge core_clk) disable iff (!reset_n)
        (branch_valid && !branch_fixed && $past(s_q.cur_periph))
        |-> (!req_pending[branch_number[4:0]] || $past(req_set[s_q.cur_num[4:0]])))
        else $error("request bit not cleared on accept");
    a_req_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        (vec_rd_req && !vec_rd_ack) |=> (vec_rd_req && $stable(vec_rd_addr)))
        else $error("vector read dropped before ack");
    a_step_raise: assert property (@(posedge core_clk) disable iff (!reset_n)
        (instr_retired && debug_flag) |=> s_q.spec[SP_STEP])
        else $error("single step not raised");

endmodule : interrupt_source_vectoring

// >>> intvec_pkg.sv
package intvec_pkg;

    // ==========================================================
    // fixed vector entries, four bytes each, up to the top of memory
    localparam logic [19:0] VEC_UNDEF = 20'hfffdc;
    localparam logic [19:0] VEC_OVF = 20'hfffe0;
    localparam logic [19:0] VEC_BRK = 20'hfffe4;
    localparam logic [19:0] VEC_AMATCH = 20'hfffe8;
    localparam logic [19:0] VEC_STEP = 20'hfffec;
    localparam logic [19:0] VEC_WDT = 20'hffff0;
    localparam logic [19:0] VEC_DBC = 20'hffff4;
    localparam logic [19:0] VEC_NMI = 20'hffff8;
    localparam logic [19:0] VEC_RESET = 20'hffffc;
    localparam logic [7:0] BRK_RELOC_MARK = 8'hff;

    // ==========================================================
    // relocatable table: 64 entries of four bytes, 256 bytes
    localparam int RELOC_BYTES = 256;
    localparam logic [5:0] TRAP_SHARED_LAST = 6'h1f;
    localparam logic [5:0] TRAP_BRK_NUM = 6'h00;

    // ==========================================================
    // request bit positions, equal to the shared trap number
    localparam int KEY_VEC = 13;
    localparam int EXT_A_VEC = 29;
    localparam int EXT_B_VEC = 30;
    localparam int EXT_C_VEC = 31;
    localparam logic [31:0] PERIPH_IN_MASK = 32'h1fff_dfe0;
    localparam logic [31:0] MASKABLE_MASK = 32'hffff_ffe0;
    localparam int KEY_PINS = 4;

    // ==========================================================
    // non-maskable pending bits, lower index wins
    localparam int SP_RESET = 0;
    localparam int SP_DBC = 1;
    localparam int SP_WDT = 2;
    localparam int SP_NMI = 3;
    localparam int SP_UND = 4;
    localparam int SP_OVF = 5;
    localparam int SP_BRK = 6;
    localparam int SP_TRAP = 7;
    localparam int SP_AMATCH = 8;
    localparam int SP_STEP = 9;
    localparam int SPEC_N = 10;

    // ==========================================================
    // edge select encoding per external pin
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    // ==========================================================
    // reset values
    localparam logic IE_RST = 1'b0;
    localparam logic USEL_RST = 1'b0;
    localparam logic PIN_IDLE = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_RELOC = 2'b11,
        ST_BRANCH = 2'b10
    } fsm_state_t;

endpackage : intvec_pkg

// >>> input_conditioner.sv
`timescale 1ns/100ps
module input_conditioner
    import intvec_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [2*WIDTH-1:0] edge_sel,
    output logic [WIDTH-1:0] level_q,
    output logic [WIDTH-1:0] edge_q
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] edg;
    } cond_t;

    cond_t st_q;
    cond_t st_d;

    // s1 feeds only s2; edges are seen between s2 and s3
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            st_d.edg[i] = (edge_sel[2*i] & st_q.s2[i] & ~st_q.s3[i])
                | (edge_sel[2*i+1] & ~st_q.s2[i] & st_q.s3[i]);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q.s1 <= {WIDTH{PIN_IDLE}};
            st_q.s2 <= {WIDTH{PIN_IDLE}};
            st_q.s3 <= {WIDTH{PIN_IDLE}};
            st_q.edg <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign level_q = st_q.s2;
    assign edge_q = st_q.edg;

endmodule : input_conditioner

// >>> vec_mem_model.sv
`timescale 1ns/100ps
// ==========================================================
// vector memory on the core side: answers entry reads after a set wait
module vec_mem_model
    import intvec_pkg::*;
#(
    parameter logic [19:0] KEY = 20'h12345
)(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic vec_rd_req,
    input wire logic [19:0] vec_rd_addr,
    input wire logic [3:0] wait_cycles,
    input wire logic brk_mark,
    output logic vec_rd_ack,
    output logic [31:0] vec_rd_data
);
    logic [3:0] cnt_q;

    // data toggles outside the ack cycle so a stale word never looks valid
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= 4'h0;
            vec_rd_ack <= 1'b0;
            vec_rd_data <= 32'h0;
        end
        else if (vec_rd_ack)
        begin
            vec_rd_ack <= 1'b0;
            cnt_q <= 4'h0;
            vec_rd_data <= ~vec_rd_data;
        end
        else if (vec_rd_req && cnt_q >= wait_cycles)
        begin
            vec_rd_ack <= 1'b1;
            vec_rd_data <= (brk_mark && vec_rd_addr == VEC_BRK) ?
                {24'h0, BRK_RELOC_MARK} : {12'h0, vec_rd_addr ^ KEY};
        end
        else
        begin
            cnt_q <= vec_rd_req ? cnt_q + 4'h1 : 4'h0;
            vec_rd_data <= ~vec_rd_data;
        end
    end
endmodule : vec_mem_model

// >>> interrupt_source_vectoring_bench.sv
`timescale 1ns/100ps
module interrupt_source_vectoring_bench import intvec_pkg::*;;
    localparam logic [19:0] KEY = 20'h12345;
    logic core_clk, reset_n, undefined_opcode_instr, overflow_trap_instr, overflow_flag;
    logic break_instr, trap_instr, instr_retired, debug_flag, instr_start, addr_match_enable;
    logic watchdog_req, debugger_break_int, nmi_pin_n, ext_edge_int_a, ext_edge_int_b;
    logic ext_edge_int_c, int_enable_set, int_enable_clear, stack_select_wr;
    logic stack_select_wdata, int_return, vec_rd_req, vec_rd_ack, branch_valid, branch_fixed;
    logic int_enable, stack_select, brk_mark;
    logic [5:0] trap_number, branch_number;
    logic [19:0] instr_addr, addr_match_value, vector_table_base, vec_rd_addr, branch_addr, ia;
    logic [KEY_PINS-1:0] key_input_pin_n;
    logic [1:0] ext_edge_sel_a, ext_edge_sel_b, ext_edge_sel_c;
    logic [31:0] periph_req, req_clear, vec_rd_data, req_pending;
    logic [3:0] ack_wait;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int k;
    logic [19:0] fixv[7] = '{VEC_UNDEF, VEC_OVF, VEC_BRK, VEC_WDT, VEC_DBC, VEC_STEP, VEC_AMATCH};
    int trn[4] = '{3, 31, 32, 63};
    int pbit[6] = '{5, 8, 10, 11, 21, 28};

    interrupt_source_vectoring u_interrupt_source_vectoring (
        .core_clk, .reset_n, .undefined_opcode_instr, .overflow_trap_instr, .overflow_flag,
        .break_instr, .trap_instr, .trap_number, .instr_retired, .debug_flag, .instr_start,
        .instr_addr, .addr_match_enable, .addr_match_value, .watchdog_req, .debugger_break_int,
        .nmi_pin_n, .key_input_pin_n, .ext_edge_int_a, .ext_edge_int_b, .ext_edge_int_c,
        .ext_edge_sel_a, .ext_edge_sel_b, .ext_edge_sel_c, .periph_req, .req_clear,
        .int_enable_set, .int_enable_clear, .stack_select_wr, .stack_select_wdata, .int_return,
        .vector_table_base, .vec_rd_req, .vec_rd_addr, .vec_rd_ack, .vec_rd_data, .branch_valid,
        .branch_addr, .branch_fixed, .branch_number, .int_enable, .stack_select, .req_pending
    );

    vec_mem_model #(.KEY(KEY)) u_vec_mem_model (
        .core_clk, .reset_n, .vec_rd_req, .vec_rd_addr, .wait_cycles(ack_wait), .brk_mark,
        .vec_rd_ack, .vec_rd_data
    );

    // ==========================================================
    // clock and hang guard
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // ==========================================================
    // tasks
    task automatic stop_test();
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_br(input logic [19:0] ent, input logic fx, input logic [5:0] nb);
        for (int i = 0; i < 60 && branch_valid !== 1'b1; i++)
            @(negedge core_clk);
        chk("branch_valid", 1, branch_valid);
        chk("branch_addr", ent ^ KEY, branch_addr);
        chk("branch_fixed", fx, branch_fixed);
        if (!fx)
            chk("branch_number", nb, branch_number);
        @(negedge core_clk);
    endtask : wait_br

    task automatic no_br(input int n);
        repeat (n)
        begin
            @(negedge core_clk);
            chk("no_branch", 0, branch_valid);
        end
    endtask : no_br

    // one-cycle request of kind k, raised and dropped on falling edges
    task automatic fire(input int k);
        case (k)
            0: undefined_opcode_instr = 1'b1;
            1: overflow_trap_instr = 1'b1;
            2: break_instr = 1'b1;
            3: watchdog_req = 1'b1;
            4: debugger_break_int = 1'b1;
            5: {debug_flag, instr_retired} = 2'b11;
            6: {instr_start, instr_addr} = {1'b1, ia};
            default: trap_instr = 1'b1;
        endcase
        @(negedge core_clk);
        {undefined_opcode_instr, overflow_trap_instr, break_instr, watchdog_req} = 4'h0;
        {debugger_break_int, debug_flag, instr_retired, instr_start, trap_instr} = 5'h0;
    endtask : fire

    task automatic strobe_en(input logic s, input logic c);
        {int_enable_set, int_enable_clear} = {s, c};
        @(negedge core_clk);
        {int_enable_set, int_enable_clear} = 2'b00;
    endtask : strobe_en

    // ==========================================================
    // main sequence
    initial
    begin
        {reset_n, undefined_opcode_instr, overflow_trap_instr, overflow_flag, break_instr} = 0;
        {trap_instr, instr_retired, debug_flag, instr_start, watchdog_req, brk_mark} = 0;
        {debugger_break_int, int_enable_set, int_enable_clear, stack_select_wr, int_return} = 0;
        // edge pins idle high, the level their synchronisers reset to
        {ext_edge_int_a, ext_edge_int_b, ext_edge_int_c, stack_select_wdata} = 4'he;
        {ext_edge_sel_a, ext_edge_sel_b, ext_edge_sel_c} = {EDGE_RISE, EDGE_FALL, EDGE_BOTH};
        {nmi_pin_n, addr_match_enable, trap_number, instr_addr} = {2'b11, 6'h0, 20'h0};
        {addr_match_value, vector_table_base, ia} = {20'h01234, 20'h0c400, 20'h01234};
        {key_input_pin_n, periph_req, req_clear, ack_wait} = {4'hf, 32'h0, 32'h0, 4'h0};
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        wait_br(VEC_RESET, 1'b1, 6'h0);
        chk("int_enable", 0, int_enable);
        overflow_flag = 1'b1;
        for (k = 0; k < 7; k++)
        begin
            ack_wait = 4'(k % 4);
            fire(k);
            wait_br(fixv[k], 1'b1, 6'h0);
        end
        overflow_flag = 1'b0;
        fire(1);
        ia = addr_match_value + 20'h1;
        fire(6);
        addr_match_enable = 1'b0;
        ia = addr_match_value;
        fire(6);
        no_br(10);
        brk_mark = 1'b1;
        fire(2);
        wait_br(vector_table_base, 1'b0, 6'h0);
        brk_mark = 1'b0;
        for (k = 0; k < 4; k++)
        begin
            {stack_select_wr, stack_select_wdata} = 2'b11;
            @(negedge core_clk);
            stack_select_wr = 1'b0;
            trap_number = 6'(trn[k]);
            fire(7);
            wait_br(vector_table_base + 20'(4 * trn[k]), 1'b0, 6'(trn[k]));
            chk("stack_select", trn[k] > 31, stack_select);
            int_return = 1'b1;
            @(negedge core_clk);
            int_return = 1'b0;
            @(negedge core_clk);
            chk("stack_select", 1, stack_select);
        end
        nmi_pin_n = 1'b0;
        wait_br(VEC_NMI, 1'b1, 6'h0);
        nmi_pin_n = 1'b1;
        periph_req[14] = 1'b1;
        @(negedge core_clk);
        periph_req[14] = 1'b0;
        no_br(8);
        chk("pending_14", 1, req_pending[14]);
        strobe_en(1'b1, 1'b0);
        chk("int_enable", 1, int_enable);
        wait_br(vector_table_base + 20'd56, 1'b0, 6'd14);
        chk("pending_14", 0, req_pending[14]);
        for (k = 0; k < 6; k++)
        begin
            periph_req[pbit[k]] = 1'b1;
            @(negedge core_clk);
            periph_req = 32'h0;
            wait_br(vector_table_base + 20'(4 * pbit[k]), 1'b0, 6'(pbit[k]));
        end
        strobe_en(1'b0, 1'b1);
        chk("int_enable", 0, int_enable);
        key_input_pin_n = 4'b1011;
        repeat (3) @(negedge core_clk);
        key_input_pin_n = 4'hf;
        no_br(5);
        chk("pending_13", 1, req_pending[KEY_VEC]);
        req_clear[KEY_VEC] = 1'b1;
        @(negedge core_clk);
        req_clear = 32'h0;
        @(negedge core_clk);
        chk("pending_13", 0, req_pending[KEY_VEC]);
        // falling edges: only the falling and both-edge pins may request
        {ext_edge_int_a, ext_edge_int_b, ext_edge_int_c} = 3'b000;
        no_br(4);
        chk("pending_29", 0, req_pending[EXT_A_VEC]);
        chk("pending_30", 1, req_pending[EXT_B_VEC]);
        chk("pending_31", 1, req_pending[EXT_C_VEC]);
        req_clear = 32'hc000_0000;
        @(negedge core_clk);
        req_clear = 32'h0;
        {ext_edge_int_a, ext_edge_int_c} = 2'b11;
        no_br(6);
        chk("pending_30", 0, req_pending[EXT_B_VEC]);
        strobe_en(1'b1, 1'b0);
        wait_br(vector_table_base + 20'd116, 1'b0, 6'(EXT_A_VEC));
        wait_br(vector_table_base + 20'd124, 1'b0, 6'(EXT_C_VEC));
        stop_test();
    end
endmodule : interrupt_source_vectoring_bench
